// ### rtl/hbsf_frame.v
// Serial slave frame logic with daisy chain, global fault flag and register map
//
// Overview of operation
// - Token bit is 1 only in the final address byte; device checks it.
// - Before first rising clock, output shows own fault flag OR serial input.
// - Status bytes arrive in reverse chain order after the fault flag.
// - Response bytes follow the status bytes in reverse chain order.
// - With select low and no clock, output still shows combined fault flag.
// - Failure after the address byte shows in next frame's global status.
// - New target fault during read-and-clear data byte suppresses the clear.
// - Data-byte fault shows in this response, global status only next frame.
// - Control register: operation bit 0 reads, 1 writes the data byte.
// - Status register: operation bit 1 reads then clears, 0 reads.
// - Five address bits decode twelve control, one config, seven status.
// - Input sampled on falling clock, output shifted on rising clock.
// - Bad clock count flags protocol error in the next frame.
// - Fault flag ORs global status bits, power-on bit inverted.
// - On select rising, act on the word and release the output.
`timescale 1ns/10ps
`include "hbsf_map.vh"

module hbsf_frame (
  input  wire        clock_i,
  input  wire        rst_n_i,
  input  wire        chip_select_n_i,
  input  wire        serial_clock_i,
  input  wire        serial_input_i,
  input  wire [47:0] status_event_i,
  input  wire [3:0]  system_event_i,
  output reg         serial_output_o,
  output reg         serial_output_oe_o,
  output reg         global_fault_flag_o,
  output wire [95:0] control_o
);

  // ************************************************************
  // Address decoder
  // ************************************************************
  function [5:0] hbsf_decode;
    input [4:0] a;
    begin
      case (a)
        `HBSF_HALF_BRIDGE_ACT_A:    hbsf_decode = {`HBSF_KIND_CTRL, 4'h0};
        `HBSF_CONTROL_WORD_I:       hbsf_decode = {`HBSF_KIND_CTRL, 4'h1};
        `HBSF_BRIDGE_CONFIG_B:      hbsf_decode = {`HBSF_KIND_CTRL, 4'h2};
        `HBSF_HALF_BRIDGE_ACT_C:    hbsf_decode = {`HBSF_KIND_CTRL, 4'h3};
        `HBSF_CONTROL_WORD_K:       hbsf_decode = {`HBSF_KIND_CTRL, 4'h4};
        `HBSF_PULSE_CHANNEL_FREQ:   hbsf_decode = {`HBSF_KIND_CTRL, 4'h5};
        `HBSF_HALF_BRIDGE_ACT_B:    hbsf_decode = {`HBSF_KIND_CTRL, 4'h6};
        `HBSF_CONTROL_WORD_J:       hbsf_decode = {`HBSF_KIND_CTRL, 4'h7};
        `HBSF_BRIDGE_CONFIG_C:      hbsf_decode = {`HBSF_KIND_CTRL, 4'h8};
        `HBSF_BRIDGE_CONFIG_A:      hbsf_decode = {`HBSF_KIND_CTRL, 4'h9};
        `HBSF_CONTROL_WORD_L:       hbsf_decode = {`HBSF_KIND_CTRL, 4'ha};
        `HBSF_CONTROL_WORD_H:       hbsf_decode = {`HBSF_KIND_CTRL, 4'hb};
        `HBSF_DEVICE_CONFIGURATION: hbsf_decode = {`HBSF_KIND_CFG,  4'h0};
        `HBSF_SYSTEM_DIAGNOSIS_A:   hbsf_decode = {`HBSF_KIND_STAT, 4'h0};
        `HBSF_SYSTEM_DIAGNOSIS_B:   hbsf_decode = {`HBSF_KIND_STAT, 4'h1};
        `HBSF_SYSTEM_DIAGNOSIS_C:   hbsf_decode = {`HBSF_KIND_STAT, 4'h2};
        `HBSF_SYSTEM_DIAGNOSIS_D:   hbsf_decode = {`HBSF_KIND_STAT, 4'h3};
        `HBSF_SYSTEM_DIAGNOSIS_E:   hbsf_decode = {`HBSF_KIND_STAT, 4'h4};
        `HBSF_SYSTEM_DIAGNOSIS_F:   hbsf_decode = {`HBSF_KIND_STAT, 4'h5};
        `HBSF_SYSTEM_DIAGNOSIS_G:   hbsf_decode = {`HBSF_KIND_STAT, 4'h6};
        default:                    hbsf_decode = {`HBSF_KIND_NONE, 4'h0};
      endcase
    end
  endfunction

  // ************************************************************
  // Storage
  // ************************************************************
  reg  [7:0]  ctrl [0:11];
  reg  [7:0]  stat [0:6];
  reg  [2:0]  s_cs;
  reg  [2:0]  s_ck;
  reg  [1:0]  s_di;
  reg         in_frame;
  reg         first_rise;
  reg  [7:0]  bit_cnt;
  reg  [15:0] rx;
  reg  [7:0]  tx;
  reg  [2:0]  rcnt;
  reg         resp_live;
  reg  [1:0]  tgt_kind;
  reg  [3:0]  tgt_idx;
  reg         tgt_op;
  reg         tgt_seen;
  reg         hit;
  reg         token_seen;
  reg         pol_err;
  reg         gef_snap;
  reg  [7:0]  next_tx;
  reg  [7:0]  rd_val;
  reg  [7:0]  ev_tgt;
  reg         frame_err;
  wire        cs_fall;
  wire        cs_rise;
  wire        ck_rise;
  wire        ck_fall;
  wire        load_err;
  wire [7:0]  gsb;
  wire        global_fault_flag;
  wire [7:0]  byte_in;
  wire [5:0]  dec;
  wire [7:0]  stat_ev [0:6];
  integer     i;

  // ************************************************************
  // Pin synchronisers and edge detection
  // ************************************************************
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_cs <= 3'h7;
      s_ck <= 3'h0;
      s_di <= 2'h0;
    end else begin
      s_cs <= {s_cs[1:0], chip_select_n_i};
      s_ck <= {s_ck[1:0], serial_clock_i};
      s_di <= {s_di[0], serial_input_i};
    end
  end

  assign cs_fall = s_cs[2] & ~s_cs[1];
  assign cs_rise = ~s_cs[2] & s_cs[1];
  assign ck_rise = in_frame & ~s_ck[2] & s_ck[1];
  assign ck_fall = in_frame & s_ck[2] & ~s_ck[1];
  assign byte_in = {s_di[1], rx[15:9]};
  assign dec     = hbsf_decode(byte_in[`HBSF_ADDR_MSB:`HBSF_ADDR_LSB]);

  // ************************************************************
  // Global status and fault flag
  // ************************************************************
  assign stat_ev[0] = {2'h0, system_event_i[3:2], 1'b0, system_event_i[1:0], 1'b0};
  genvar g;
  generate
    for (g = 1; g < 7; g = g + 1) begin : g_ev
      assign stat_ev[g] = status_event_i[8*g-1 -: 8];
    end
  endgenerate

  assign load_err = |{stat[1], stat[2], stat[3], stat[4], stat[5], stat[6]};
  assign gsb = {stat[0][`HBSF_GS_SPI_ERR], load_err, stat[0][5:1], 1'b0};
  assign global_fault_flag = |{gsb[7:4], ~gsb[`HBSF_GS_POWER_ON_RESET_N_FLAG], gsb[2:1]};

  generate
    for (g = 0; g < 12; g = g + 1) begin : g_out
      assign control_o[8*g+7 -: 8] = ctrl[g];
    end
  endgenerate

  // ************************************************************
  // Read mux, live target events and error check
  // ************************************************************
  // Events of the reload cycle join the read value, later ones block the clear
  always @* begin
    case (dec[5:4])
      `HBSF_KIND_CTRL: rd_val = ctrl[dec[3:0]];
      `HBSF_KIND_CFG:  rd_val = `HBSF_DEV_CONFIG;
      `HBSF_KIND_STAT: rd_val = ((dec[3:0] == 4'h0) ? gsb : stat[dec[2:0]]) | stat_ev[dec[2:0]];
      default:         rd_val = 8'h00;
    endcase
    ev_tgt = (tgt_kind == `HBSF_KIND_STAT) ? stat_ev[tgt_idx[2:0]] : 8'h00;
    frame_err = pol_err | s_ck[1];
    if (bit_cnt != 8'h00) begin
      if ((bit_cnt[2:0] != 3'h0) || (bit_cnt < `HBSF_MIN_FRAME) || (bit_cnt == 8'hff))
        frame_err = 1'b1;
      if (!tgt_seen || (tgt_kind == `HBSF_KIND_NONE) || !token_seen)
        frame_err = 1'b1;
    end
  end

  // Next output byte: shift on rising, reload with a whole byte on the eighth falling
  always @* begin
    next_tx = tx;
    if (ck_rise)
      next_tx = {1'b0, tx[7:1]};
    else if (ck_fall && bit_cnt[2:0] == 3'h7) begin
      if (bit_cnt == 8'h07 && byte_in[`HBSF_ADDR_ONE_BIT])
        next_tx = rd_val;
      else
        next_tx = byte_in;
    end
    if (resp_live && !(ck_fall && bit_cnt[2:0] == 3'h7))
      next_tx = next_tx | (ev_tgt >> (rcnt + (ck_rise ? 3'h1 : 3'h0)));
  end

  // ************************************************************
  // Frame engine
  // ************************************************************
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_frame            <= 1'b0;
      first_rise          <= 1'b0;
      bit_cnt             <= 8'h00;
      rx                  <= 16'h0000;
      tx                  <= 8'h00;
      rcnt                <= 3'h0;
      resp_live           <= 1'b0;
      tgt_kind            <= `HBSF_KIND_NONE;
      tgt_idx             <= 4'h0;
      tgt_op              <= 1'b0;
      tgt_seen            <= 1'b0;
      hit                 <= 1'b0;
      token_seen          <= 1'b0;
      pol_err             <= 1'b0;
      gef_snap            <= 1'b1;
      serial_output_o     <= 1'b0;
      serial_output_oe_o  <= 1'b0;
      global_fault_flag_o <= 1'b1;
    end else begin
      global_fault_flag_o <= global_fault_flag;
      tx <= next_tx;
      // Global status is frozen at select fall, so later faults wait a frame
      if (cs_fall) begin
        in_frame           <= 1'b1;
        first_rise         <= 1'b0;
        bit_cnt            <= 8'h00;
        tx                 <= gsb;
        rcnt               <= 3'h0;
        resp_live          <= 1'b0;
        tgt_seen           <= 1'b0;
        tgt_kind           <= `HBSF_KIND_NONE;
        hit                <= 1'b0;
        token_seen         <= 1'b0;
        pol_err            <= s_ck[1];
        gef_snap           <= global_fault_flag;
        serial_output_oe_o <= 1'b1;
        serial_output_o    <= global_fault_flag | s_di[1];
      end else if (cs_rise) begin
        in_frame           <= 1'b0;
        resp_live          <= 1'b0;
        serial_output_oe_o <= 1'b0;
        serial_output_o    <= 1'b0;
      end else if (in_frame) begin
        if (!first_rise)
          serial_output_o <= gef_snap | s_di[1];
        if (ck_rise) begin
          first_rise      <= 1'b1;
          serial_output_o <= tx[0];
          rcnt            <= rcnt + 3'h1;
        end
        if (ck_fall) begin
          rx <= {s_di[1], rx[15:1]};
          if (bit_cnt != 8'hff)
            bit_cnt <= bit_cnt + 8'h01;
          if (bit_cnt[2:0] == 3'h7) begin
            rcnt      <= 3'h0;
            resp_live <= 1'b0;
            if (byte_in[1:0] == 2'h3)
              token_seen <= 1'b1;
            if (bit_cnt == 8'h07) begin
              tgt_seen  <= 1'b1;
              tgt_kind  <= byte_in[`HBSF_ADDR_ONE_BIT] ? dec[5:4] : `HBSF_KIND_NONE;
              tgt_idx   <= dec[3:0];
              tgt_op    <= byte_in[`HBSF_ADDR_OP_BIT];
              resp_live <= byte_in[`HBSF_ADDR_ONE_BIT] && dec[5:4] == `HBSF_KIND_STAT;
            end
          end
        end
        // Event after the read value was taken: keep it past a clear
        if (bit_cnt >= 8'h08 && |ev_tgt)
          hit <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Register update on select rising
  // ************************************************************
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < 12; i = i + 1)
        ctrl[i] <= `HBSF_CTRL_RESET;
      for (i = 0; i < 7; i = i + 1)
        stat[i] <= `HBSF_STAT_RESET;
    end else begin
      // Events set bits every cycle; a clear in the same cycle loses to them
      for (i = 0; i < 7; i = i + 1)
        stat[i] <= stat[i] | stat_ev[i];
      if (cs_rise && in_frame) begin
        if (frame_err)
          stat[0][`HBSF_GS_SPI_ERR] <= 1'b1;
        else if (bit_cnt != 8'h00 && tgt_op) begin
          if (tgt_kind == `HBSF_KIND_CTRL)
            ctrl[tgt_idx] <= rx[15:8];
          if (tgt_kind == `HBSF_KIND_STAT && !hit) begin
            stat[tgt_idx[2:0]] <= stat_ev[tgt_idx[2:0]];
            if (tgt_idx == 4'h0)
              stat[0][`HBSF_GS_POWER_ON_RESET_N_FLAG] <= 1'b1;
          end
        end
      end
    end
  end

endmodule // hbsf_frame

// ### rtl/hbsf_map.vh
// Constants for the half-bridge serial frame logic: offsets, fields, reset values
`ifndef HBSF_MAP_VH
`define HBSF_MAP_VH

// ************************************************************
// Address byte fields (LSB shifted first)
// ************************************************************
`define HBSF_ADDR_ONE_BIT    0
`define HBSF_ADDR_TOKEN_BIT  1
`define HBSF_ADDR_OP_BIT     7
`define HBSF_ADDR_LSB        2
`define HBSF_ADDR_MSB        6

// ************************************************************
// Register offsets, five-bit address field
// ************************************************************
`define HBSF_HALF_BRIDGE_ACT_A      5'h00
`define HBSF_SYSTEM_DIAGNOSIS_E     5'h01
`define HBSF_CONTROL_WORD_I         5'h02
`define HBSF_BRIDGE_CONFIG_B        5'h04
`define HBSF_SYSTEM_DIAGNOSIS_A     5'h06
`define HBSF_HALF_BRIDGE_ACT_C      5'h08
`define HBSF_SYSTEM_DIAGNOSIS_G     5'h09
`define HBSF_CONTROL_WORD_K         5'h0a
`define HBSF_PULSE_CHANNEL_FREQ     5'h0c
`define HBSF_SYSTEM_DIAGNOSIS_C     5'h0e
`define HBSF_HALF_BRIDGE_ACT_B      5'h10
`define HBSF_SYSTEM_DIAGNOSIS_F     5'h11
`define HBSF_CONTROL_WORD_J         5'h12
`define HBSF_BRIDGE_CONFIG_C        5'h14
`define HBSF_SYSTEM_DIAGNOSIS_B     5'h16
`define HBSF_BRIDGE_CONFIG_A        5'h18
`define HBSF_DEVICE_CONFIGURATION   5'h19
`define HBSF_CONTROL_WORD_L         5'h1a
`define HBSF_CONTROL_WORD_H         5'h1c
`define HBSF_SYSTEM_DIAGNOSIS_D     5'h1e

// ************************************************************
// Register kinds returned by the address decoder
// ************************************************************
`define HBSF_KIND_CTRL  2'h0
`define HBSF_KIND_CFG   2'h1
`define HBSF_KIND_STAT  2'h2
`define HBSF_KIND_NONE  2'h3

// ************************************************************
// Global status byte fields and reset values
// ************************************************************
`define HBSF_GS_SPI_ERR   7
`define HBSF_GS_LOAD_ERR  6
`define HBSF_GS_VS_UV     5
`define HBSF_GS_VS_OV     4
`define HBSF_GS_POWER_ON_RESET_N_FLAG      3
`define HBSF_GS_TSD       2
`define HBSF_GS_TPW       1
`define HBSF_STAT_RESET   8'h00
`define HBSF_CTRL_RESET   8'h00
`define HBSF_DEV_CONFIG   8'h5a
`define HBSF_MIN_FRAME    8'h10

`endif

// ### verif/hbsf_master.sv
// Serial bus master model driving one frame at a time
`timescale 1ns/10ps
module hbsf_master (
  input  wire       clock_i,
  input  wire       master_input_line_i,
  output reg        chip_select_n_o,
  output reg        serial_clock_o,
  output reg        master_output_line_o,
  output reg  [7:0] bit_count_o
);
  reg [32:0] rx_word;
  initial begin
    chip_select_n_o = 1'b1;
    serial_clock_o = 1'b0;
    master_output_line_o = 1'b0;
    bit_count_o = 8'h00;
  end
  // Input line is taken just before each rise, when it has settled
  task frame(input [31:0] tx, input integer nbits);
    integer i;
    begin
      bit_count_o <= 8'h00;
      chip_select_n_o <= 1'b0;
      master_output_line_o <= 1'b0;
      repeat (8) @(posedge clock_i);
      for (i = 0; i < nbits; i = i + 1) begin
        rx_word[i] = master_input_line_i;
        serial_clock_o <= 1'b1;
        master_output_line_o <= tx[i];
        repeat (4) @(posedge clock_i);
        serial_clock_o <= 1'b0;
        bit_count_o <= i[7:0] + 8'h01;
        repeat (4) @(posedge clock_i);
      end
      rx_word[nbits] = master_input_line_i;
      chip_select_n_o <= 1'b1;
      repeat (12) @(posedge clock_i);
    end
  endtask
endmodule // hbsf_master

// ### verif/hbsf_monitor.sv
// Port checker for the half-bridge serial frame logic
`timescale 1ns/10ps
module hbsf_monitor (
  input wire        clock_i,
  input wire        rst_n_i,
  input wire        chip_select_n_i,
  input wire        serial_clock_i,
  input wire        serial_input_i,
  input wire [47:0] status_event_i,
  input wire [3:0]  system_event_i,
  input wire        serial_output_o,
  input wire        serial_output_oe_o,
  input wire        global_fault_flag_o,
  input wire [95:0] control_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  AST_OE_ON: assert property ($fell(chip_select_n_i) |-> ##[2:5] serial_output_oe_o)
    else $error("output enable late");
  AST_OE_OFF: assert property ($rose(chip_select_n_i) |-> ##[2:5] !serial_output_oe_o)
    else $error("output not released");
  AST_OUT_OFF: assert property (!serial_output_oe_o |-> !serial_output_o)
    else $error("output high while released");
  AST_OE_HOLD: assert property ((!chip_select_n_i)[*6] |-> serial_output_oe_o)
    else $error("output enable lost in frame");
  AST_OE_CAUSE: assert property ($rose(serial_output_oe_o) |-> !$past(chip_select_n_i, 2))
    else $error("output enable without select");
  AST_CTRL_END: assert property ($changed(control_o) |->
    chip_select_n_i && $past(chip_select_n_i)) else $error("control changed in frame");
  AST_FLAG_POR: assert property ($rose(rst_n_i) |-> global_fault_flag_o)
    else $error("fault flag low after reset");
  AST_FLAG_SYS: assert property ((|system_event_i) |-> ##[1:6] global_fault_flag_o)
    else $error("fault flag missed event");
endmodule // hbsf_monitor

bind hbsf_frame hbsf_monitor hbsf_monitor_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .chip_select_n_i(chip_select_n_i), .serial_clock_i(serial_clock_i),
  .serial_input_i(serial_input_i), .status_event_i(status_event_i),
  .system_event_i(system_event_i), .serial_output_o(serial_output_o),
  .serial_output_oe_o(serial_output_oe_o), .global_fault_flag_o(global_fault_flag_o),
  .control_o(control_o));

// ### verif/spi_daisy_chain_frame_logic_tb.sv
// Self-checking bench of the frame logic against a register model
`timescale 1ns/10ps
module spi_daisy_chain_frame_logic_tb;
  localparam [31:0] CTRL_MASK = 32'h15151515;
  localparam [31:0] STAT_MASK = 32'h40424242;
  reg         clock_i, rst_n_i;
  reg  [47:0] status_event;
  reg  [3:0]  system_event;
  wire        cs_n, sclk, sin, sout, sout_oe, flag;
  wire [95:0] control;
  wire [7:0]  bit_count;
  integer     err_count, samples_checked, seed, k, a;
  reg  [7:0]  d, gs;
  reg  [7:0]  regs [0:31];
  reg  [4:0]  so [0:5];
  reg  [31:0] bad_tx [0:3];

  hbsf_frame hbsf_frame_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .chip_select_n_i(cs_n),
    .serial_clock_i(sclk), .serial_input_i(sin), .status_event_i(status_event),
    .system_event_i(system_event), .serial_output_o(sout), .serial_output_oe_o(sout_oe),
    .global_fault_flag_o(flag), .control_o(control));
  hbsf_master hbsf_master_i (.clock_i(clock_i), .master_input_line_i(sout),
    .chip_select_n_o(cs_n), .serial_clock_o(sclk), .master_output_line_o(sin),
    .bit_count_o(bit_count));

  function logic [7:0] gsv();
    gsv = gs | ((|{regs[5'h16], regs[5'h0e], regs[5'h1e], regs[5'h01], regs[5'h11],
      regs[5'h09]}) ? 8'h40 : 8'h00);
  endfunction
  task check(input string what, input [7:0] exp, input [7:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // One 16-bit frame; events are pulsed during the data byte
  task xfer(input [4:0] ad, input op, input [7:0] dt, input [3:0] se, input [47:0] te);
    reg [7:0] g, r;
    integer j;
    begin
      g = gsv();
      r = (ad == 5'h06) ? g : regs[ad];
      for (j = 0; j < 6; j = j + 1)
        if (so[j] == ad) r = r | te[8*j +: 8];
      fork
        hbsf_master_i.frame({16'h0000, dt, op, ad, 2'b11}, 16);
        if (se != 4'h0 || te != 48'h0) begin
          wait (bit_count == 8'h08);
          repeat (3) @(posedge clock_i);
          system_event <= se;
          status_event <= te;
          @(posedge clock_i);
          system_event <= 4'h0;
          status_event <= 48'h0;
        end
      join
      check("flag", {7'h00, |(g ^ 8'h08)}, {7'h00, hbsf_master_i.rx_word[0]});
      check("status", g, hbsf_master_i.rx_word[8:1]);
      check("response", r, hbsf_master_i.rx_word[16:9]);
      if (op && CTRL_MASK[ad]) regs[ad] = dt;
      if (op && ad == 5'h06) gs = 8'h08;
      if (op && STAT_MASK[ad] && te == 48'h0) regs[ad] = 8'h00;
      for (j = 0; j < 6; j = j + 1)
        regs[so[j]] = regs[so[j]] | te[8*j +: 8];
      gs = gs | {2'b00, se[3:2], 1'b0, se[1:0], 1'b0};
      check("flag out", {7'h00, |(gsv() ^ 8'h08)}, {7'h00, flag});
      check("release", 8'h00, {7'h00, sout_oe});
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  initial begin
    #200000;
    err_count = err_count + 1;
    results;
  end
  initial begin
    err_count = 0; samples_checked = 0; seed = 3; gs = 8'h00;
    rst_n_i = 1'b0; status_event = 48'h0; system_event = 4'h0;
    for (k = 0; k < 32; k = k + 1) regs[k] = 8'h00;
    regs[5'h19] = 8'h5a;
    so[0] = 5'h16; so[1] = 5'h0e; so[2] = 5'h1e; so[3] = 5'h01; so[4] = 5'h11; so[5] = 5'h09;
    bad_tx[0] = 32'h0000000f; bad_tx[1] = 32'h00000003;
    bad_tx[2] = 32'h00000101; bad_tx[3] = 32'h00000002;
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    hbsf_master_i.frame(32'h0, 0);
    check("poll flag", 8'h01, {7'h00, hbsf_master_i.rx_word[0]});
    xfer(5'h06, 1'b1, 8'h00, 4'h0, 48'h0);
    $display("test 1 done");
    k = 0;
    for (a = 0; a < 32; a = a + 1)
      if (CTRL_MASK[a]) begin
        d = 8'($random(seed));
        xfer(a[4:0], 1'b1, d, 4'h0, 48'h0);
        xfer(a[4:0], 1'b0, ~d, 4'h0, 48'h0);
        xfer(a[4:0], 1'b0, 8'h00, 4'h0, 48'h0);
        check("control", regs[a], control[8*k +: 8]);
        k = k + 1;
      end
    hbsf_master_i.frame({8'h00, ~d, d, 8'h03}, 32);
    check("chain response", regs[0], hbsf_master_i.rx_word[16:9]);
    check("pass byte 2", d, hbsf_master_i.rx_word[24:17]);
    check("pass byte 3", ~d, hbsf_master_i.rx_word[32:25]);
    xfer(5'h19, 1'b0, 8'h00, 4'h0, 48'h0);
    $display("test 2 done");
    for (k = 0; k < 4; k = k + 1) begin
      hbsf_master_i.frame(bad_tx[k], (k == 1) ? 12 : (k == 2) ? 24 : 16);
      gs = gs | 8'h80;
      xfer(5'h00, 1'b0, 8'h00, 4'h0, 48'h0);
      xfer(5'h06, 1'b1, 8'h00, 4'h0, 48'h0);
    end
    $display("test 3 done");
    for (k = 0; k < 4; k = k + 1) begin
      xfer(5'h00, 1'b0, 8'h00, 4'h1 << k, 48'h0);
      xfer(5'h06, 1'b1, 8'h00, 4'h0, 48'h0);
    end
    for (k = 0; k < 6; k = k + 1) begin
      d = 8'($random(seed)) | 8'h01;
      xfer(so[k], 1'b1, 8'h00, 4'h0, {40'h0, d} << (8 * k));
      xfer(so[k], 1'b1, 8'h00, 4'h0, 48'h0);
    end
    $display("test 4 done");
    results;
  end
endmodule // spi_daisy_chain_frame_logic_tb
